// file: rtl/pmta_addr_decode.sv
`include "pmta_params.svh"
module pmta_addr_decode
(
   // strap resistor already decoded to a 0..7 index
   input wire logic [2:0] address_select_high,
   input wire logic [2:0] address_select_low,
   input wire logic single_pin_address_option,
   output logic [6:0] addr
);
   import pmta_pkg::*;
   logic [6:0] raw;
   always_comb
   begin
      raw = {1'b0, address_select_high, 3'h0};
      if (!single_pin_address_option)
      begin
         raw = raw | {4'h0, address_select_low};
      end
      if (raw == `PMTA_ADDR_ZERO || raw == `PMTA_ADDR_RSV1 ||
          raw == `PMTA_ADDR_RSV2)
      begin
         addr = `PMTA_ADDR_SUBST;
      end
      else
      begin
         addr = raw;
      end
   end
endmodule : pmta_addr_decode

// file: rtl/pmta_device.sv
`include "pmta_params.svh"
// ---------------------------------------------------------------
// target end: runs on scl; faults and measurements come from clk
// ---------------------------------------------------------------
module pmta_device
(
   pmta_link_if.device link,
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] address_select_high,
   input wire logic [2:0] address_select_low,
   input wire logic [7:0] fault_in,
   input wire logic output_enable,
   input wire logic busy_in,
   input wire logic [15:0] meas_vin,
   input wire logic [15:0] meas_vout,
   input wire logic [15:0] meas_iout,
   input wire logic [15:0] meas_temp_int,
   input wire logic [15:0] meas_temp_ext,
   input wire logic [15:0] meas_freq,
   input wire logic [15:0] meas_duty,
   output logic [7:0] status_ff
);
   import pmta_pkg::*;
   // -----------------------------------------------------------
   // link side, clocked by scl (falling edge drives, rising samples); start/stop flops clock on sda edges
   // -----------------------------------------------------------
   pmta_tst_type st_ff;
   logic [7:0] sh_ff;
   logic [3:0] cnt_ff;
   logic [7:0] cmd_ff;
   logic [1:0] byte_ff;
   logic rd_ff;
   logic start_tg_ff;
   logic stop_tg_ff;
   logic sda_d_ff;
   logic [6:0] my_addr;
   logic [7:0] mask_l_ff;
   logic single_l_ff;
   logic temp_sel_l_ff;
   logic clear_tg_l_ff;
   logic [15:0] rdata;
   logic [2:0] st_sync_ff;
   logic [2:0] sp_sync_ff;
   logic [7:0] live_ff;
   logic [7:0] stat_l_ff;
   logic busy_l_ff;
   // start/stop seen as sda edges while scl high
   always_ff @(negedge link.sda or negedge rstn)
   begin
      if (!rstn) start_tg_ff <= 1'b0;
      else if (link.scl) start_tg_ff <= !start_tg_ff;
   end
   always_ff @(posedge link.sda or negedge rstn)
   begin
      if (!rstn) stop_tg_ff <= 1'b0;
      else if (link.scl) stop_tg_ff <= !stop_tg_ff;
   end
   pmta_addr_decode u_dec
   (
      .address_select_high(address_select_high),
      .address_select_low(address_select_low),
      .single_pin_address_option(single_l_ff),
      .addr(my_addr)
   );
   // a start resets the byte engine: remembered at scl rise
   logic start_ack_ff;
   logic start_pend;
   assign start_pend = start_tg_ff != start_ack_ff;
   always_comb
   begin
      case (cmd_ff)
         `PMTA_CMD_READ_VIN: rdata = meas_vin;
         `PMTA_CMD_READ_VOUT: rdata = meas_vout;
         `PMTA_CMD_READ_IOUT: rdata = meas_iout;
         `PMTA_CMD_READ_TEMP1: rdata = temp_sel_l_ff ? meas_temp_ext
            : meas_temp_int;
         `PMTA_CMD_READ_FREQ: rdata = meas_freq;
         `PMTA_CMD_READ_DUTY: rdata = meas_duty;
         `PMTA_CMD_STATUS_BYTE: rdata = {8'h00, stat_l_ff};
         `PMTA_CMD_STATUS_WORD: rdata = {fault_in, stat_l_ff};
         `PMTA_CMD_STATUS_VOUT: rdata = {15'h0000, fault_in[0]};
         `PMTA_CMD_STATUS_IOUT: rdata = {15'h0000, fault_in[1]};
         `PMTA_CMD_STATUS_INPUT: rdata = {15'h0000, fault_in[2]};
         `PMTA_CMD_STATUS_TEMP: rdata = {15'h0000, fault_in[3]};
         `PMTA_CMD_STATUS_CML: rdata = {15'h0000, fault_in[4]};
         `PMTA_CMD_STATUS_MFR: rdata = {8'h00, fault_in[7:5], 5'h00};
         `PMTA_CMD_SMBALERT_MASK: rdata = {8'h00, mask_l_ff};
         default: rdata = 16'hFFFF;
      endcase
   end
   // byte engine on scl rising edge
   always_ff @(posedge link.scl or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff <= PMTA_T_IDLE;
         sh_ff <= 8'h00;
         cnt_ff <= 4'h0;
         cmd_ff <= 8'h00;
         byte_ff <= 2'h0;
         rd_ff <= 1'b0;
         start_ack_ff <= 1'b0;
         mask_l_ff <= 8'h00;
         single_l_ff <= 1'b0;
         temp_sel_l_ff <= 1'b0;
         clear_tg_l_ff <= 1'b0;
      end
      else if (start_pend)
      begin
         start_ack_ff <= start_tg_ff;
         st_ff <= PMTA_T_ADDR;
         sh_ff <= {7'h00, link.sda};
         cnt_ff <= 4'h1;
         byte_ff <= 2'h0;
      end
      else
      begin
         case (st_ff)
            PMTA_T_ADDR:
            begin
               sh_ff <= {sh_ff[6:0], link.sda};
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == 4'h7)
               begin
                  rd_ff <= link.sda;
                  st_ff <= (sh_ff[6:0] == my_addr) ? PMTA_T_ACK
                     : PMTA_T_WAIT;
               end
            end
            PMTA_T_ACK:
            begin
               cnt_ff <= 4'h0;
               byte_ff <= 2'h0;
               st_ff <= rd_ff ? PMTA_T_SEND : PMTA_T_DATA;
            end
            PMTA_T_DATA:
            begin
               sh_ff <= {sh_ff[6:0], link.sda};
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == 4'h7)
               begin
                  st_ff <= PMTA_T_DACK;
                  if (byte_ff == 2'h0)
                  begin
                     cmd_ff <= {sh_ff[6:0], link.sda};
                     if ({sh_ff[6:0], link.sda} == `PMTA_CMD_CLEAR_FAULTS)
                        clear_tg_l_ff <= !clear_tg_l_ff;
                  end
                  else if (byte_ff == 2'h1)
                  begin
                     case (cmd_ff)
                        `PMTA_CMD_SMBALERT_MASK:
                           mask_l_ff <= {sh_ff[6:0], link.sda};
                        `PMTA_CMD_TEMP_SELECT: temp_sel_l_ff <= link.sda;
                        `PMTA_CMD_SINGLE_PIN: single_l_ff <= link.sda;
                        default: ;
                     endcase
                  end
               end
            end
            PMTA_T_DACK:
            begin
               cnt_ff <= 4'h0;
               if (byte_ff != 2'h3) byte_ff <= byte_ff + 2'h1;
               st_ff <= PMTA_T_DATA;
            end
            PMTA_T_SEND:
            begin
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == 4'h7) st_ff <= PMTA_T_MACK;
            end
            PMTA_T_MACK:
            begin
               cnt_ff <= 4'h0;
               byte_ff <= byte_ff + 2'h1;
               st_ff <= link.sda ? PMTA_T_WAIT : PMTA_T_SEND;
            end
            PMTA_T_WAIT: st_ff <= PMTA_T_WAIT;
            PMTA_T_IDLE: st_ff <= PMTA_T_IDLE;
            default: st_ff <= PMTA_T_IDLE;
         endcase
      end
   end
   // drive sda on falling scl so data is stable through high phase
   logic [2:0] bit_idx;
   assign bit_idx = 3'h7 - cnt_ff[2:0];
   always_ff @(negedge link.scl or negedge rstn)
   begin
      if (!rstn) sda_d_ff <= 1'b0;
      else if (st_ff == PMTA_T_ACK || st_ff == PMTA_T_DACK)
         sda_d_ff <= 1'b1;
      else if (st_ff == PMTA_T_SEND)
         sda_d_ff <= byte_ff[0] ? !rdata[{1'b1, bit_idx}]
            : !rdata[{1'b0, bit_idx}];
      else sda_d_ff <= 1'b0;
   end
   assign link.sda_dev_o = 1'b0;
   assign link.sda_dev_oe = sda_d_ff;
   // -----------------------------------------------------------
   // system side on clk: alert latch and status
   // -----------------------------------------------------------
   logic [2:0] clr_sync_ff;
   logic [2:0] oen_sync_ff;
   logic [7:0] fault_ff;
   logic alert_ff;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         clr_sync_ff <= 3'h0;
         oen_sync_ff <= 3'h0;
      end
      else
      begin
         clr_sync_ff <= {clr_sync_ff[1:0], clear_tg_l_ff};
         oen_sync_ff <= {oen_sync_ff[1:0], output_enable};
      end
   end
   logic clr_evt;
   logic reen_evt;
   logic [7:0] nxt_fault;
   assign clr_evt = clr_sync_ff[2] != clr_sync_ff[1];
   assign reen_evt = oen_sync_ff[1] && !oen_sync_ff[2];
   // mask is quasi static; crossing it as level is accepted
   always_comb
   begin
      nxt_fault = fault_ff;
      if (clr_evt || reen_evt) nxt_fault = 8'h00;
      nxt_fault = nxt_fault | (fault_in & ~mask_l_ff);
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fault_ff <= 8'h00;
         alert_ff <= 1'b0;
         status_ff <= 8'h00;
      end
      else
      begin
         fault_ff <= nxt_fault;
         alert_ff <= |nxt_fault;
         status_ff <= {busy_in, 6'h00, |fault_ff};
      end
   end
   assign link.alert_oe = alert_ff;
   // status seen on link side; word sampled at scl rise is stable
   always_ff @(posedge link.scl or negedge rstn)
   begin
      if (!rstn) stat_l_ff <= 8'h00;
      else stat_l_ff <= status_ff;
   end
   assign link.scl_dev_oe = 1'b0;
endmodule : pmta_device

// file: rtl/pmta_host.sv
`include "pmta_params.svh"
module pmta_host
#(
   parameter int SCL_HZ = `PMTA_SCL_100K_HZ
)
(
   pmta_link_if.host link,
   input wire logic clk,
   input wire logic rstn,
   input wire logic req,
   input wire logic [6:0] req_addr,
   input wire logic [7:0] req_cmd,
   input wire logic req_read,
   input wire logic [7:0] req_wdata,
   output logic busy,
   output logic [15:0] rdata_ff,
   output logic nack_ff,
   output logic alert_ff
);
   import pmta_pkg::*;
   localparam int HALF = `PMTA_CLK_HZ / SCL_HZ / 2;
   localparam int FREE = (`PMTA_BUS_FREE_NS * (`PMTA_CLK_HZ / 1000000)
      + 999) / 1000;
   pmta_hst_type st_ff;
   logic [15:0] div_ff;
   logic ph_ff;
   logic [4:0] bit_ff;
   logic [2:0] byte_ff;
   logic [7:0] sh_ff;
   logic scl_ff;
   logic sda_ff;
   logic [2:0] sda_s_ff;
   logic [2:0] scl_s_ff;
   logic [2:0] al_s_ff;
   logic rd_ff;
   logic [6:0] a_ff;
   logic [7:0] c_ff;
   logic [7:0] w_ff;
   logic tick;
   logic stretched;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sda_s_ff <= 3'h7;
         scl_s_ff <= 3'h7;
         al_s_ff <= 3'h7;
      end
      else
      begin
         sda_s_ff <= {sda_s_ff[1:0], link.sda};
         scl_s_ff <= {scl_s_ff[1:0], link.scl};
         al_s_ff <= {al_s_ff[1:0], link.fault_alert_line};
      end
   end
   // wait while the target holds scl low
   assign stretched = scl_ff && !scl_s_ff[2] && !scl_s_ff[1];
   assign tick = div_ff == 16'(HALF - 1) && !stretched;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn) div_ff <= 16'h0000;
      else if (st_ff == PMTA_H_IDLE || tick) div_ff <= 16'h0000;
      else if (!stretched) div_ff <= div_ff + 16'h0001;
   end
   assign busy = st_ff != PMTA_H_IDLE;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff <= PMTA_H_IDLE;
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
         ph_ff <= 1'b0;
         bit_ff <= 5'h00;
         byte_ff <= 3'h0;
         sh_ff <= 8'h00;
         rd_ff <= 1'b0;
         a_ff <= 7'h00;
         c_ff <= 8'h00;
         w_ff <= 8'h00;
         rdata_ff <= 16'h0000;
         nack_ff <= 1'b0;
         alert_ff <= 1'b0;
      end
      else
      begin
         if (al_s_ff[2] == al_s_ff[1]) alert_ff <= !al_s_ff[2];
         case (st_ff)
            PMTA_H_IDLE:
               if (req)
               begin
                  a_ff <= req_addr;
                  c_ff <= req_cmd;
                  w_ff <= req_wdata;
                  rd_ff <= req_read;
                  nack_ff <= 1'b0;
                  byte_ff <= 3'h0;
                  st_ff <= PMTA_H_START;
               end
            PMTA_H_START, PMTA_H_RSTART:
               if (tick)
               begin
                  if (!ph_ff)
                  begin
                     scl_ff <= 1'b1;
                     sda_ff <= 1'b1;
                     ph_ff <= 1'b1;
                  end
                  else
                  begin
                     sda_ff <= 1'b0;
                     ph_ff <= 1'b0;
                     bit_ff <= 5'h00;
                     sh_ff <= {byte_ff == 3'h2 ? a_ff : a_ff,
                        byte_ff == 3'h2};
                     st_ff <= PMTA_H_BIT;
                  end
               end
            PMTA_H_BIT:
               if (tick)
               begin
                  if (!ph_ff)
                  begin
                     scl_ff <= 1'b0;
                     ph_ff <= 1'b1;
                  end
                  else if (scl_ff == 1'b0)
                     scl_ff <= 1'b1;
                  else
                  begin
                     if (byte_ff > 3'h2 && rd_ff)
                        rdata_ff <= {rdata_ff[14:0], sda_s_ff[2]};
                     sh_ff <= {sh_ff[6:0], 1'b0};
                     ph_ff <= 1'b0;
                     bit_ff <= bit_ff + 5'h01;
                     if (bit_ff == 5'h07) st_ff <= PMTA_H_ACK;
                  end
               end
               // data moves mid-low so it never races a clock edge
               else if (ph_ff && !scl_ff && div_ff == 16'(HALF / 2))
                  sda_ff <= (byte_ff > 3'h2 && rd_ff) ? 1'b1 : sh_ff[7];
            PMTA_H_ACK:
               if (tick)
               begin
                  if (!ph_ff)
                  begin
                     scl_ff <= 1'b0;
                     ph_ff <= 1'b1;
                  end
                  else if (!scl_ff)
                     scl_ff <= 1'b1;
                  else
                  begin
                     ph_ff <= 1'b0;
                     bit_ff <= 5'h00;
                     if (byte_ff < 3'h2 && sda_s_ff[2]) nack_ff <= 1'b1;
                     byte_ff <= byte_ff + 3'h1;
                     sh_ff <= byte_ff == 3'h0 ? c_ff : w_ff;
                     if (nack_ff || (byte_ff < 3'h2 && sda_s_ff[2]))
                        st_ff <= PMTA_H_STOP;
                     else if (byte_ff == 3'h1 && rd_ff)
                     begin
                        scl_ff <= 1'b0;
                        st_ff <= PMTA_H_RSTART;
                     end
                     else if ((byte_ff == 3'h2 && !rd_ff) || byte_ff == 3'h4)
                        st_ff <= PMTA_H_STOP;
                     else st_ff <= PMTA_H_BIT;
                  end
               end
               // master acks first read byte, nacks last
               else if (ph_ff && !scl_ff && div_ff == 16'(HALF / 2))
                  sda_ff <= !(byte_ff == 3'h3 && rd_ff);
            PMTA_H_STOP:
               if (tick)
               begin
                  if (!ph_ff)
                  begin
                     scl_ff <= 1'b0;
                     ph_ff <= 1'b1;
                  end
                  else if (!scl_ff) scl_ff <= 1'b1;
                  else
                  begin
                     sda_ff <= 1'b1;
                     ph_ff <= 1'b0;
                     bit_ff <= 5'h00;
                     st_ff <= PMTA_H_FREE;
                  end
               end
               else if (ph_ff && !scl_ff && div_ff == 16'(HALF / 2))
                  sda_ff <= 1'b0;
            PMTA_H_FREE:
               if (tick)
               begin
                  bit_ff <= bit_ff + 5'h01;
                  if (32'(bit_ff) * 32'(HALF) >= 32'(FREE))
                     st_ff <= PMTA_H_IDLE;
               end
            default: st_ff <= PMTA_H_IDLE;
         endcase
      end
   end
   assign link.scl_o = 1'b0;
   assign link.scl_oe = !scl_ff;
   assign link.sda_host_o = 1'b0;
   assign link.sda_host_oe = !sda_ff;
endmodule : pmta_host

// file: rtl/pmta_link_if.sv
interface pmta_link_if;
   logic scl_o;
   logic scl_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic scl_dev_oe;
   logic alert_oe;
   logic scl;
   logic sda;
   logic fault_alert_line;
   // open drain: any enabled driver pulls low
   assign scl = !(scl_oe && !scl_o) && !scl_dev_oe;
   assign sda = !(sda_host_oe && !sda_host_o) && !sda_dev_oe;
   assign fault_alert_line = !alert_oe;
   modport device (input scl, input sda, output sda_dev_o,
      output sda_dev_oe, output scl_dev_oe, output alert_oe);
   modport host (input scl, input sda, input fault_alert_line,
      output scl_o, output scl_oe, output sda_host_o, output sda_host_oe);
endinterface : pmta_link_if

// file: rtl/pmta_params.svh
`ifndef PMTA_PARAMS_SVH
`define PMTA_PARAMS_SVH
// What this block does
// - link runs only at 100 or 400 kHz; host scl is low one half period, high two, so 66.7 kHz at 100 kHz and 277.8 kHz at 400 kHz
// - pmbus command set plus separate alert line
// - each select pin decodes to index 0..7
// - address is eight times high plus low
// - computed 0, 11 or 12 becomes 127
// - single pin option ignores low select pin
// - standard smbus protocol with clock stretching
// - busy flag set when too occupied
// - host leaves bus free between stop, start
// - host waits 5 ms after nvm store; the host has no such wait and goes idle after the bus free time
// - host should append and check pec; the host sends and checks no pec
// - monitoring reads return live measurements
// - temperature read follows sensor select command
// - alert low on any enabled fault
// - alert held until clear or output re-enable
// - masked faults never raise the alert
// - status commands report fault causes
`define PMTA_ADDR_ZERO 7'h00
`define PMTA_ADDR_RSV1 7'h0B
`define PMTA_ADDR_RSV2 7'h0C
`define PMTA_ADDR_SUBST 7'h7F
`define PMTA_ADDR_MUL 3
// command codes
`define PMTA_CMD_CLEAR_FAULTS 8'h03
`define PMTA_CMD_STORE_USER_ALL 8'h15
`define PMTA_CMD_SMBALERT_MASK 8'h1B
`define PMTA_CMD_STATUS_BYTE 8'h78
`define PMTA_CMD_STATUS_WORD 8'h79
`define PMTA_CMD_STATUS_VOUT 8'h7A
`define PMTA_CMD_STATUS_IOUT 8'h7B
`define PMTA_CMD_STATUS_INPUT 8'h7C
`define PMTA_CMD_STATUS_TEMP 8'h7D
`define PMTA_CMD_STATUS_CML 8'h7E
`define PMTA_CMD_STATUS_MFR 8'h80
`define PMTA_CMD_READ_VIN 8'h88
`define PMTA_CMD_READ_VOUT 8'h8B
`define PMTA_CMD_READ_IOUT 8'h8C
`define PMTA_CMD_READ_TEMP1 8'h8D
`define PMTA_CMD_READ_DUTY 8'h94
`define PMTA_CMD_READ_FREQ 8'h95
`define PMTA_CMD_TEMP_SELECT 8'hDC
`define PMTA_CMD_SINGLE_PIN 8'hE5
// status byte fields
`define PMTA_BUSY_BIT 7
`define PMTA_CML_BIT 1
// host timing
`define PMTA_CLK_HZ 10000000
`define PMTA_SCL_100K_HZ 100000
`define PMTA_SCL_400K_HZ 400000
`define PMTA_BUS_FREE_NS 4700
`define PMTA_NVM_WAIT_MS 5
`endif

// file: rtl/pmta_pkg.sv
package pmta_pkg;
   typedef enum logic [1:0] {PMTA_OP_WRITE, PMTA_OP_READ} pmta_op_type;
   typedef enum {PMTA_T_IDLE, PMTA_T_ADDR, PMTA_T_ACK, PMTA_T_DATA,
      PMTA_T_DACK, PMTA_T_SEND, PMTA_T_MACK, PMTA_T_WAIT} pmta_tst_type;
   typedef enum {PMTA_H_IDLE, PMTA_H_START, PMTA_H_BIT, PMTA_H_ACK,
      PMTA_H_RSTART, PMTA_H_STOP, PMTA_H_FREE} pmta_hst_type;
endpackage : pmta_pkg

// file: tb/pmbus_target_address_alert_bench.sv
`include "pmta_params.svh"
module pmbus_target_address_alert_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import pmta_pkg::*;
   logic clk, rstn, req, req_read, busy, nack_ff, alert_ff;
   logic output_enable, busy_in;
   logic [6:0] req_addr;
   logic [7:0] req_cmd, req_wdata, fault_in, status_ff;
   logic [2:0] sel_hi, sel_lo;
   logic [15:0] rdata_ff;
   logic [15:0] meas [7];
   int mismatches, checked;
   logic [7:0] rd_cmd [6] = '{`PMTA_CMD_READ_VIN, `PMTA_CMD_READ_VOUT,
      `PMTA_CMD_READ_IOUT, `PMTA_CMD_READ_TEMP1, `PMTA_CMD_READ_FREQ,
      `PMTA_CMD_READ_DUTY};
   int rd_idx [6] = '{0, 1, 2, 3, 5, 6};
   int pr_hi [5] = '{0, 1, 1, 7, 5};
   int pr_lo [5] = '{0, 3, 4, 7, 2};
   pmta_link_if link_if();
   pmta_host #(.SCL_HZ(`PMTA_SCL_400K_HZ)) pmta_host_inst (
      .link(link_if.host), .clk(clk), .rstn(rstn), .req(req),
      .req_addr(req_addr), .req_cmd(req_cmd), .req_read(req_read),
      .req_wdata(req_wdata), .busy(busy), .rdata_ff(rdata_ff),
      .nack_ff(nack_ff), .alert_ff(alert_ff));
   pmta_device pmta_device_inst (.link(link_if.device), .clk(clk),
      .rstn(rstn), .address_select_high(sel_hi),
      .address_select_low(sel_lo), .fault_in(fault_in),
      .output_enable(output_enable), .busy_in(busy_in),
      .meas_vin(meas[0]), .meas_vout(meas[1]), .meas_iout(meas[2]),
      .meas_temp_int(meas[3]), .meas_temp_ext(meas[4]),
      .meas_freq(meas[5]), .meas_duty(meas[6]), .status_ff(status_ff));
   pmta_link_sva pmta_link_sva_inst (.clk(clk), .rstn(rstn),
      .scl(link_if.scl), .sda(link_if.sda),
      .scl_dev_oe(link_if.scl_dev_oe), .sda_dev_oe(link_if.sda_dev_oe),
      .alert_oe(link_if.alert_oe));
   // ----------------------------------------------------------
   // tasks
   // ----------------------------------------------------------
   task test_done;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   task check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // req is a level: drop it once taken so the host does not repeat
   task xfer(input logic [6:0] a, input logic [7:0] c, input logic rd,
      input logic [7:0] wd);
      int n;
      @(posedge clk);
      req <= 1'b1;
      req_addr <= a;
      req_cmd <= c;
      req_read <= rd;
      req_wdata <= wd;
      n = 0;
      do @(negedge clk); while (busy !== 1'b1 && ++n < 20);
      @(posedge clk);
      req <= 1'b0;
      n = 0;
      do @(negedge clk); while (busy !== 1'b0 && ++n < 20000);
      check(16'(n < 20000), 16'h0001);
   endtask : xfer
   function automatic logic [6:0] addr_of(input int h, input int l);
      int a;
      a = 8 * h + l;
      return (a == 0 || a == 11 || a == 12) ? 7'h7F : 7'(a);
   endfunction : addr_of
   // ----------------------------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      repeat (90000) @(posedge clk);
      mismatches++;
      test_done;
   end
   initial
   begin
      rstn = 1'b0;
      req = 1'b0;
      req_addr = 7'h00;
      req_cmd = 8'h00;
      req_read = 1'b0;
      req_wdata = 8'h00;
      fault_in = 8'h00;
      output_enable = 1'b1;
      busy_in = 1'b0;
      sel_hi = 3'h1;
      sel_lo = 3'h2;
      for (int i = 0; i < 7; i++)
         meas[i] = {8'(i + 1), 8'hA0 + 8'(i)};
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      tick(3);
      xfer(7'h0A, `PMTA_CMD_TEMP_SELECT, 1'b0, 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         xfer(7'h0A, rd_cmd[i], 1'b1, 8'h00);
         check(rdata_ff, {meas[rd_idx[i]][7:0], meas[rd_idx[i]][15:8]});
      end
      xfer(7'h0A, `PMTA_CMD_TEMP_SELECT, 1'b0, 8'h01);
      xfer(7'h0A, `PMTA_CMD_READ_TEMP1, 1'b1, 8'h00);
      check(rdata_ff, {meas[4][7:0], meas[4][15:8]});
      xfer(7'h0B, `PMTA_CMD_STATUS_BYTE, 1'b1, 8'h00);
      check(16'(nack_ff), 16'h0001);
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clk);
         sel_hi <= 3'(pr_hi[i]);
         sel_lo <= 3'(pr_lo[i]);
         tick(3);
         xfer(addr_of(pr_hi[i], pr_lo[i]), `PMTA_CMD_STATUS_BYTE, 1'b1,
            8'h00);
         check(16'(nack_ff), 16'h0000);
         xfer(7'(8 * pr_hi[i] + pr_lo[i]), `PMTA_CMD_STATUS_BYTE, 1'b1,
            8'h00);
         check(16'(nack_ff), {15'h0, addr_of(pr_hi[i], pr_lo[i]) == 7'h7F});
      end
      xfer(7'h2A, `PMTA_CMD_SINGLE_PIN, 1'b0, 8'h01);
      xfer(7'h28, `PMTA_CMD_STATUS_BYTE, 1'b1, 8'h00);
      check(16'(nack_ff), 16'h0000);
      xfer(7'h2A, `PMTA_CMD_STATUS_BYTE, 1'b1, 8'h00);
      check(16'(nack_ff), 16'h0001);
      xfer(7'h28, `PMTA_CMD_SINGLE_PIN, 1'b0, 8'h00);
      @(posedge clk);
      fault_in <= 8'h01;
      tick(20);
      check(16'(alert_ff), 16'h0001);
      check(16'(status_ff[0]), 16'h0001);
      @(posedge clk);
      fault_in <= 8'h00;
      tick(20);
      check(16'(alert_ff), 16'h0001);
      xfer(7'h2A, `PMTA_CMD_CLEAR_FAULTS, 1'b0, 8'h00);
      tick(20);
      check(16'(alert_ff), 16'h0000);
      @(posedge clk);
      fault_in <= 8'h01;
      tick(20);
      fault_in <= 8'h00;
      output_enable <= 1'b0;
      tick(5);
      output_enable <= 1'b1;
      tick(20);
      check(16'(alert_ff), 16'h0000);
      xfer(7'h2A, `PMTA_CMD_SMBALERT_MASK, 1'b0, 8'h01);
      @(posedge clk);
      fault_in <= 8'h01;
      tick(20);
      check(16'(alert_ff), 16'h0000);
      @(posedge clk);
      fault_in <= 8'h02;
      tick(20);
      check(16'(alert_ff), 16'h0001);
      @(posedge clk);
      fault_in <= 8'h00;
      busy_in <= 1'b1;
      xfer(7'h2A, `PMTA_CMD_STATUS_BYTE, 1'b1, 8'h00);
      check(16'(rdata_ff[15]), 16'h0001);
      check(16'(status_ff[7]), 16'h0001);
      test_done;
   end
endmodule : pmbus_target_address_alert_bench

// file: tb/pmta_link_sva.sv
module pmta_link_sva
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_dev_oe,
   input wire logic sda_dev_oe,
   input wire logic alert_oe
);
   localparam int BUS_FREE_MIN = 45;
   localparam int SCL_PER_MIN = 23;
   logic scl_q_ff;
   logic sda_q_ff;
   logic bus_busy_ff;
   logic [7:0] free_cnt_ff;
   logic [7:0] per_cnt_ff;
   logic start_ev;
   logic stop_ev;
   logic scl_rise;
   assign start_ev = scl && scl_q_ff && sda_q_ff && !sda;
   assign stop_ev = scl && scl_q_ff && !sda_q_ff && sda;
   assign scl_rise = scl && !scl_q_ff;
   // ----------------------------------------------------------
   // line history and bus framing
   // ----------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end
      else
      begin
         scl_q_ff <= scl;
         sda_q_ff <= sda;
      end
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         bus_busy_ff <= 1'b0;
      else if (start_ev || stop_ev)
         bus_busy_ff <= start_ev;
   end
   // counters saturate so a long idle never wraps into a false gap
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         free_cnt_ff <= 8'hFF;
      else if (stop_ev)
         free_cnt_ff <= 8'h00;
      else if (free_cnt_ff != 8'hFF)
         free_cnt_ff <= free_cnt_ff + 8'h01;
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         per_cnt_ff <= 8'hFF;
      else if (scl_rise)
         per_cnt_ff <= 8'h00;
      else if (per_cnt_ff != 8'hFF)
         per_cnt_ff <= per_cnt_ff + 8'h01;
   end
   // ----------------------------------------------------------
   // properties
   // ----------------------------------------------------------
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence seq_scl_fall;
      ##[1:200] !scl;
   endsequence
   chk_no_stretch: assert property (!scl_dev_oe)
      else $error("device held the clock low");
   chk_dev_change_low: assert property ($changed(sda_dev_oe) |-> !scl)
      else $error("device moved data while clock high");
   chk_dev_bit_held: assert property (scl && $past(scl) &&
      $past(sda_dev_oe) |-> sda_dev_oe)
      else $error("device bit not held through high phase");
   chk_bus_free_gap: assert property (start_ev |->
      free_cnt_ff >= BUS_FREE_MIN)
      else $error("start too soon after stop");
   chk_scl_rate: assert property (scl_rise |->
      per_cnt_ff >= SCL_PER_MIN)
      else $error("clock period too short");
   chk_idle_scl_high: assert property (!bus_busy_ff |-> scl)
      else $error("clock low outside a frame");
   chk_idle_sda_free: assert property (!bus_busy_ff |-> !sda_dev_oe)
      else $error("device drives data outside a frame");
   chk_alert_hold: assert property ($rose(alert_oe) |=> alert_oe [*3])
      else $error("alert released too early");
endmodule : pmta_link_sva
